// >>> hw/klp_pkg.sv
// Purpose: Shared constants of the key and LED panel I/O block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses; colour and brightness codes are small enums.

package klp_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] KLP_OFF_KEYS    = 8'h00;  // Key states, keys 0..31.
   localparam logic [7:0] KLP_OFF_COL0    = 8'h04;  // Colours of LEDs 0..7.
   localparam logic [7:0] KLP_OFF_COL1    = 8'h08;  // Colours of LEDs 8..15.
   localparam logic [7:0] KLP_OFF_COL2    = 8'h0c;  // Colours of LEDs 16..23.
   localparam logic [7:0] KLP_OFF_COL3    = 8'h10;  // Colours of LEDs 24..31.
   localparam logic [7:0] KLP_OFF_LAMPCFG = 8'h14;  // Lamp test duration and brightness.
   localparam logic [7:0] KLP_OFF_CTRL    = 8'h18;  // Lamp test start and status.
   localparam logic [7:0] KLP_OFF_DIN     = 8'h1c;  // Discrete inputs.
   localparam logic [7:0] KLP_OFF_IODIR   = 8'h20;  // Terminal direction, 1 = output.
   localparam logic [7:0] KLP_OFF_IOOUT   = 8'h24;  // Terminal output values.
   localparam logic [7:0] KLP_OFF_IOIN    = 8'h28;  // Terminal input levels.

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int         KLP_DUR_LSB     = 0;      // Duration field, 6 bits, seconds.
   localparam int         KLP_BRT_LSB     = 8;      // Brightness field, 3 bits.
   localparam int         KLP_COL_STRIDE  = 4;      // One nibble per LED colour.
   localparam logic [5:0] KLP_DUR_MAX     = 6'h3c;
   localparam logic [5:0] KLP_DUR_RST     = 6'h05;
   localparam logic [2:0] KLP_BRT_MAX     = 3'h4;
   localparam logic [15:0] KLP_IODIR_RST  = 16'h0000;
   localparam int         KLP_CTRL_START  = 0;      // Write 1 starts a lamp test.
   localparam int         KLP_CTRL_BUSY   = 1;      // Reads 1 while a lamp test runs.

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int         KLP_CLK_HZ      = 100_000_000;
   localparam int         KLP_SEC_CYC     = KLP_CLK_HZ;  // Cycles in one second.
   localparam int         KLP_PWM_PERIOD  = 16;

   // ------------------------------------------------------------
   // Codes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      KLP_COL_OFF, KLP_COL_RED, KLP_COL_GREEN, KLP_COL_YELLOW, KLP_COL_BLUE, KLP_COL_WHITE
   } klp_colour_t;

   typedef enum logic [2:0] {
      KLP_BRT_VBRIGHT, KLP_BRT_BRIGHT, KLP_BRT_NORMAL, KLP_BRT_DARK, KLP_BRT_VDARK
   } klp_bright_t;

endpackage : klp_pkg

// >>> hw/klp_pwm.sv
// Purpose: Brightness modulator shared by all panel LEDs.
// Assumes: Level code is one of the five brightness codes.
// Notes:   The duty is in sixteenths; dimmer codes light the LEDs fewer cycles.

`timescale 1ns/1ns

module klp_pwm #(
   parameter int PERIOD = klp_pkg::KLP_PWM_PERIOD
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] level,
   output logic            on
);

   if (PERIOD != 16) begin : g_chk
      $error("klp_pwm supports a period of 16 cycles only");
   end

   logic [3:0] phase_q;
   logic [4:0] duty;

   // ------------------------------------------------------------
   // Duty table
   // ------------------------------------------------------------
   // Very dark keeps a small duty so a lit LED is still seen.
   assign duty = (level == klp_pkg::KLP_BRT_VBRIGHT) ? 5'h10 :
                 (level == klp_pkg::KLP_BRT_BRIGHT)  ? 5'h0c :
                 (level == klp_pkg::KLP_BRT_NORMAL)  ? 5'h08 :
                 (level == klp_pkg::KLP_BRT_DARK)    ? 5'h04 : 5'h02;
   assign on   = ({1'b0, phase_q} < duty);

   // Free running phase counter.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= 4'h0;
      end else begin
         phase_q <= phase_q + 4'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_pwm_vbright: assert property (level == 3'h0 |-> on)
      else $error("full brightness must never blank");
   a_pwm_vdark: assert property ((level == 3'h4 && phase_q == 4'h2) |-> !on)
      else $error("very dark duty too long");

endmodule : klp_pwm

// >>> hw/klp_panel_io.sv
// Purpose: Key panel I/O: 32 keys with colour LEDs, lamp test, discrete inputs and
//          16 terminals that are inputs or outputs, all reached over APB.
// Assumes: Pins are synchronous to CLK; the controller's process image is the APB master.
// Notes:   A lamp test also runs once after reset; SEC_CYC sets the one-second tick.
// Operation
// - key bit set while key held.
// - keys 0-15 group one, 16-31 group two.
// - controller bits drive each key LED.
// - five LED colours chosen by controller.
// - lamp test 0..60 s, zero disables.
// - lamp test duration defaults to five seconds.
// - one lamp test setting for all lamps.
// - five brightness levels, default normal.
// - terminals individually input or output, default input.
// - discrete input states reported to controller.
//
// Chosen here: the placing of the registers and the APB interface to the registers.

`timescale 1ns/1ns

module klp_panel_io #(
   parameter int SEC_CYC = klp_pkg::KLP_SEC_CYC
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [31:0] KEY,
   input  wire logic [15:0] DIN,
   input  wire logic [15:0] IO_I,
   output logic [15:0]      IO_O,
   output logic [15:0]      IO_OE,
   output logic [31:0]      LED_R,
   output logic [31:0]      LED_G,
   output logic [31:0]      LED_B
);

   if (SEC_CYC < 2) begin : g_chk
      $error("SEC_CYC must be at least 2");
   end

   // ------------------------------------------------------------
   // Colour decode
   // ------------------------------------------------------------
   // Returns {r,g,b}; unused codes give a dark LED rather than a random mix.
   function automatic logic [2:0] colour_rgb(input logic [2:0] code);
      logic [2:0] rgb;
      rgb = 3'h0;
      unique case (code)
         klp_pkg::KLP_COL_RED:    rgb = 3'h4;
         klp_pkg::KLP_COL_GREEN:  rgb = 3'h2;
         klp_pkg::KLP_COL_YELLOW: rgb = 3'h6;
         klp_pkg::KLP_COL_BLUE:   rgb = 3'h1;
         klp_pkg::KLP_COL_WHITE:  rgb = 3'h7;
         default:                 rgb = 3'h0;
      endcase
      return rgb;
   endfunction : colour_rgb

   logic [31:0] key_q;
   logic [15:0] din_q;
   logic [15:0] ioin_q;
   logic [31:0] col_q [4];
   logic [5:0]  dur_q;
   logic [2:0]  brt_q;
   logic [15:0] dir_q;
   logic [15:0] out_q;
   logic        lt_pend_q;
   logic        lt_busy_q;
   logic [5:0]  lt_left_q;
   logic [31:0] sec_cnt_q;
   logic        pwm_on;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire         setup   = PSEL && !PENABLE;
   wire         wr_acc  = PSEL && PENABLE && PREADY && PWRITE;
   wire         hit_col = (PADDR >= klp_pkg::KLP_OFF_COL0) && (PADDR <= klp_pkg::KLP_OFF_COL3)
                          && (PADDR[1:0] == 2'b00);
   wire [1:0]   col_idx = 2'(((PADDR - klp_pkg::KLP_OFF_COL0) >> 2));
   wire         hit_ok  = hit_col || (PADDR == klp_pkg::KLP_OFF_KEYS)
                          || (PADDR == klp_pkg::KLP_OFF_LAMPCFG)
                          || (PADDR == klp_pkg::KLP_OFF_CTRL)
                          || (PADDR == klp_pkg::KLP_OFF_DIN)
                          || (PADDR == klp_pkg::KLP_OFF_IODIR)
                          || (PADDR == klp_pkg::KLP_OFF_IOOUT)
                          || (PADDR == klp_pkg::KLP_OFF_IOIN);
   wire [5:0]   wr_dur  = PWDATA[klp_pkg::KLP_DUR_LSB +: 6];
   wire [2:0]   wr_brt  = PWDATA[klp_pkg::KLP_BRT_LSB +: 3];
   wire         lt_go   = lt_pend_q
                          || (wr_acc && PADDR == klp_pkg::KLP_OFF_CTRL
                              && PWDATA[klp_pkg::KLP_CTRL_START]);
   wire         sec_end = (sec_cnt_q == 32'(SEC_CYC - 1));

   // Read mux; keys 0-15 sit in the low half, 16-31 in the high half.
   wire [31:0]  rd_data =
      (PADDR == klp_pkg::KLP_OFF_KEYS)    ? key_q :
      hit_col                             ? col_q[col_idx] :
      (PADDR == klp_pkg::KLP_OFF_LAMPCFG) ? {21'h0, brt_q, 2'b00, dur_q} :
      (PADDR == klp_pkg::KLP_OFF_CTRL)    ? {30'h0, lt_busy_q, 1'b0} :
      (PADDR == klp_pkg::KLP_OFF_DIN)     ? {16'h0, din_q} :
      (PADDR == klp_pkg::KLP_OFF_IODIR)   ? {16'h0, dir_q} :
      (PADDR == klp_pkg::KLP_OFF_IOOUT)   ? {16'h0, out_q} :
      (PADDR == klp_pkg::KLP_OFF_IOIN)    ? {16'h0, ioin_q & ~dir_q} : 32'h0;

   // Answer registered in the setup cycle, so every access has zero wait states.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0;
      end else begin
         PREADY  <= setup;
         PSLVERR <= setup && !hit_ok;
         PRDATA  <= (setup && !PWRITE) ? rd_data : 32'h0;
      end
   end

   // ------------------------------------------------------------
   // Input sampling
   // ------------------------------------------------------------
   // Levels are sampled each cycle, so a bit sets one cycle after its key is pressed and clears one cycle after release.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         key_q  <= 32'h0;
         din_q  <= 16'h0;
         ioin_q <= 16'h0;
      end else begin
         key_q  <= KEY;
         din_q  <= DIN;
         ioin_q <= IO_I;
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   // Durations above 60 s are clamped and illegal brightness codes are ignored.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         dur_q <= klp_pkg::KLP_DUR_RST;
         brt_q <= klp_pkg::KLP_BRT_NORMAL;
         dir_q <= klp_pkg::KLP_IODIR_RST;
         out_q <= 16'h0;
      end else if (wr_acc) begin
         if (PADDR == klp_pkg::KLP_OFF_LAMPCFG) begin
            dur_q <= (wr_dur > klp_pkg::KLP_DUR_MAX) ? klp_pkg::KLP_DUR_MAX : wr_dur;
            if (wr_brt <= klp_pkg::KLP_BRT_MAX) begin
               brt_q <= wr_brt;
            end
         end
         if (PADDR == klp_pkg::KLP_OFF_IODIR) begin
            dir_q <= PWDATA[15:0];
         end
         if (PADDR == klp_pkg::KLP_OFF_IOOUT) begin
            out_q <= PWDATA[15:0];
         end
      end
   end

   // Colour registers, one nibble per LED.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         col_q <= '{default: 32'h0};
      end else if (wr_acc && hit_col) begin
         col_q[col_idx] <= PWDATA & 32'h77777777;
      end
   end

   // ------------------------------------------------------------
   // Lamp test
   // ------------------------------------------------------------
   // Runs once after reset and on each start write; a duration of zero skips it.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         lt_pend_q <= 1'b1;
         lt_busy_q <= 1'b0;
         lt_left_q <= 6'h0;
         sec_cnt_q <= 32'h0;
      end else begin
         lt_pend_q <= 1'b0;
         if (lt_go) begin
            lt_busy_q <= (dur_q != 6'h0);
            lt_left_q <= dur_q;
            sec_cnt_q <= 32'h0;
         end else if (lt_busy_q) begin
            sec_cnt_q <= sec_end ? 32'h0 : sec_cnt_q + 32'h1;
            if (sec_end) begin
               lt_left_q <= lt_left_q - 6'h1;
               lt_busy_q <= (lt_left_q != 6'h1);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // LED and terminal outputs
   // ------------------------------------------------------------
   klp_pwm #(
      .PERIOD (klp_pkg::KLP_PWM_PERIOD)
   ) u_pwm (
      .clk   (CLK),
      .rst_n (RSTN),
      .level (brt_q),
      .on    (pwm_on)
   );

   // Lamp test lights every LED white at the chosen brightness.
   for (genvar i = 0; i < 32; i++) begin : g_led
      wire [2:0] rgb = lt_busy_q ? 3'b111
                       : colour_rgb(col_q[i / 8][(i % 8) * klp_pkg::KLP_COL_STRIDE +: 3]);
      always_ff @(posedge CLK or negedge RSTN) begin
         if (!RSTN) begin
            LED_R[i] <= 1'b0;
            LED_G[i] <= 1'b0;
            LED_B[i] <= 1'b0;
         end else begin
            LED_R[i] <= rgb[2] && pwm_on;
            LED_G[i] <= rgb[1] && pwm_on;
            LED_B[i] <= rgb[0] && pwm_on;
         end
      end
   end

   // Output terminals drive their bit; input terminals stay released.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         IO_O  <= 16'h0;
         IO_OE <= 16'h0;
      end else begin
         IO_O  <= out_q & dir_q;
         IO_OE <= dir_q;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   sequence s_key_read;
      setup && !PWRITE && PADDR == klp_pkg::KLP_OFF_KEYS;
   endsequence

   a_key_read_data: assert property (s_key_read |=> PRDATA == $past(KEY, 2))
      else $error("key read does not show held keys");
   a_din_read_data: assert property ((setup && !PWRITE && PADDR == klp_pkg::KLP_OFF_DIN)
      |=> PRDATA[15:0] == $past(DIN, 2))
      else $error("discrete input read wrong");
   a_lamp_zero_skip: assert property ((lt_go && dur_q == 6'h0) |=> !lt_busy_q)
      else $error("zero duration started a lamp test");
   a_lamp_load_dur: assert property ((lt_go && dur_q != 6'h0)
      |=> lt_busy_q && lt_left_q == $past(dur_q))
      else $error("lamp test not loaded with duration");
   a_lamp_white: assert property ((lt_busy_q && pwm_on)
      |=> LED_R == 32'hffffffff && LED_G == 32'hffffffff && LED_B == 32'hffffffff)
      else $error("lamp test not white");
   a_led_red: assert property ((!lt_busy_q && pwm_on && col_q[0][2:0] == 3'h1)
      |=> LED_R[0] && !LED_G[0] && !LED_B[0])
      else $error("red LED colour wrong");
   a_dur_range: assert property (dur_q <= klp_pkg::KLP_DUR_MAX)
      else $error("duration above 60 s");
   a_brt_range: assert property (brt_q <= klp_pkg::KLP_BRT_MAX)
      else $error("illegal brightness stored");
   a_term_input: assert property (!dir_q[0] |=> !IO_OE[0] && !IO_O[0])
      else $error("input terminal driven");
   a_apb_answer: assert property (setup |=> PREADY && (PSLVERR == !$past(hit_ok)))
      else $error("APB answer wrong");

endmodule : klp_panel_io

// >>> tb/klp_field_model.sv
// Purpose: Field wiring of the 16 configurable terminals of the panel.
// Assumes: An external source drives each terminal that the panel leaves undriven.
// Notes:   The wire level is resolved here so the panel sees its own drive back.

`timescale 1ns/1ns

module klp_field_model (
   input  wire logic [15:0] io_o,
   input  wire logic [15:0] io_oe,
   input  wire logic [15:0] ext,
   output logic      [15:0] io_wire
);
   // ------------------------------------------------------------
   // Wire resolution
   // ------------------------------------------------------------
   // A driven terminal shows the panel's value; an input shows the field source.
   assign io_wire = (io_oe & io_o) | (~io_oe & ext);
endmodule : klp_field_model

// >>> tb/klp_panel_io_tb.sv
// Purpose: Self-checking bench of the key panel I/O block over APB.
// Assumes: SEC_CYC is shortened so that one second is 20 cycles.
// Notes:   The APB master waits for PREADY; a cycle ceiling stops a hang.

`timescale 1ns/1ns

module klp_panel_io_tb;
   localparam int SEC = 20;
   logic        clk, rstn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, key, rd, led_r, led_g, led_b;
   logic        pready, pslverr, err;
   logic [15:0] din, ext, io_i, io_o, io_oe;
   int          failures, cmp_count, cyc, cnt;
   int          duty [5] = '{16, 12, 8, 4, 2};

   klp_panel_io #(.SEC_CYC(SEC)) dut (
      .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .KEY(key), .DIN(din), .IO_I(io_i), .IO_O(io_o),
      .IO_OE(io_oe), .LED_R(led_r), .LED_G(led_g), .LED_B(led_b));

   klp_field_model field (.io_o(io_o), .io_oe(io_oe), .ext(ext), .io_wire(io_i));

   // ------------------------------------------------------------
   // Clock and cycle ceiling
   // ------------------------------------------------------------
   // The ceiling is far above the few hundred cycles the tests need.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count = cmp_count + 1;
      if (exp !== got) begin
         failures = failures + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One APB transfer; request held until PREADY is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wait_idle();
      for (int i = 0; i < 100; i++) begin
         apb(1'b0, klp_pkg::KLP_OFF_CTRL, 32'h0);
         if (rd[klp_pkg::KLP_CTRL_BUSY] === 1'b0) break;
      end
      chk("lamp test ends", 32'h0, {31'h0, rd[klp_pkg::KLP_CTRL_BUSY]});
   endtask : wait_idle

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      failures = 0;
      cmp_count = 0;
      cyc = 0;
      rstn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      key = 32'h0;
      din = 16'h0;
      ext = 16'h3c3c;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      // Reset values and the automatic lamp test of five seconds.
      apb(1'b0, klp_pkg::KLP_OFF_CTRL, 32'h0);
      chk("busy after reset", 32'h2, rd & 32'h2);
      apb(1'b0, klp_pkg::KLP_OFF_LAMPCFG, 32'h0);
      chk("lampcfg reset", 32'h0000_0205, rd);
      apb(1'b0, klp_pkg::KLP_OFF_IODIR, 32'h0);
      chk("iodir reset", 32'h0, rd);
      chk("io_oe reset", 32'h0, {16'h0, io_oe});
      wait_idle();
      $display("test reset done");
      // Keys at both ends of each group, then released.
      key <= 32'h8001_8001;
      repeat (3) @(posedge clk);
      apb(1'b0, klp_pkg::KLP_OFF_KEYS, 32'h0);
      chk("keys held", 32'h8001_8001, rd);
      key <= 32'h0;
      repeat (3) @(posedge clk);
      apb(1'b0, klp_pkg::KLP_OFF_KEYS, 32'h0);
      chk("keys released", 32'h0, rd);
      $display("test keys done");
      // Every colour code in group one, blue in group two, at full brightness.
      apb(1'b1, klp_pkg::KLP_OFF_LAMPCFG, 32'h0000_0005);
      apb(1'b1, klp_pkg::KLP_OFF_COL0, 32'h0005_4321);
      apb(1'b1, klp_pkg::KLP_OFF_COL2, 32'h0000_0004);
      apb(1'b0, klp_pkg::KLP_OFF_COL0, 32'h0);
      chk("colour readback", 32'h0005_4321, rd);
      repeat (3) @(posedge clk);
      chk("red channel", 32'h0000_0015, led_r);
      chk("green channel", 32'h0000_0016, led_g);
      chk("blue channel", 32'h0001_0018, led_b);
      $display("test colours done");
      // Lamp test: zero suppresses it, over-range clamps, one setting lights all.
      apb(1'b1, klp_pkg::KLP_OFF_LAMPCFG, 32'h0000_0000);
      apb(1'b1, klp_pkg::KLP_OFF_CTRL, 32'h1);
      apb(1'b0, klp_pkg::KLP_OFF_CTRL, 32'h0);
      chk("zero duration", 32'h0, rd & 32'h2);
      apb(1'b1, klp_pkg::KLP_OFF_LAMPCFG, 32'h0000_003d);
      apb(1'b0, klp_pkg::KLP_OFF_LAMPCFG, 32'h0);
      chk("duration clamp", 32'h0000_003c, rd);
      apb(1'b1, klp_pkg::KLP_OFF_LAMPCFG, 32'h0000_0001);
      apb(1'b1, klp_pkg::KLP_OFF_CTRL, 32'h1);
      apb(1'b0, klp_pkg::KLP_OFF_CTRL, 32'h0);
      chk("test running", 32'h2, rd & 32'h2);
      chk("all lamps red", 32'hffff_ffff, led_r);
      chk("all lamps blue", 32'hffff_ffff, led_b);
      wait_idle();
      $display("test lamp done");
      // Brightness levels as duty over one full modulator period of LED 0.
      for (int b = 0; b < 5; b++) begin
         apb(1'b1, klp_pkg::KLP_OFF_LAMPCFG, 32'(b) << klp_pkg::KLP_BRT_LSB);
         repeat (2) @(posedge clk);
         cnt = 0;
         repeat (16) begin
            @(posedge clk);
            if (led_r[0] === 1'b1) cnt = cnt + 1;
         end
         chk("duty", 32'(duty[b]), 32'(cnt));
      end
      $display("test brightness done");
      // Discrete inputs, terminal directions and the unmapped address.
      din <= 16'h1234;
      repeat (3) @(posedge clk);
      apb(1'b0, klp_pkg::KLP_OFF_DIN, 32'h0);
      chk("discrete inputs", 32'h0000_1234, rd);
      apb(1'b1, klp_pkg::KLP_OFF_IODIR, 32'h0000_00ff);
      apb(1'b1, klp_pkg::KLP_OFF_IOOUT, 32'h0000_a5a5);
      repeat (3) @(posedge clk);
      chk("io_oe", 32'h0000_00ff, {16'h0, io_oe});
      chk("io_o", 32'h0000_00a5, {16'h0, io_o});
      apb(1'b0, klp_pkg::KLP_OFF_IOIN, 32'h0);
      chk("terminal inputs", 32'h0000_3c00, rd);
      apb(1'b1, 8'h40, 32'hffff_ffff);
      chk("unmapped error", 32'h1, {31'h0, err});
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped read", 32'h0, rd);
      $display("test inputs done");
      tally_and_finish();
   end
endmodule : klp_panel_io_tb
